/* spc_pkg.sv */
package spc_pkg;
	// register addresses, byte-wide registers
	localparam logic [11:0] ADDR_REF_RATE = 12'h084;
	localparam logic [11:0] ADDR_LANE_PD = 12'h201;
	localparam logic [11:0] ADDR_CDR_RST = 12'h206;
	localparam logic [11:0] ADDR_CDR_MODE = 12'h230;
	localparam logic [11:0] ADDR_EQ_PWR = 12'h268;
	localparam logic [11:0] ADDR_PLL_CTRL = 12'h280;
	localparam logic [11:0] ADDR_PLL_STAT = 12'h281;
	localparam logic [11:0] ADDR_PLL_DIV = 12'h289;
	// field positions
	localparam int REF_MULT_LSB = 4;
	localparam int PLL_EN_BIT = 0;
	localparam int PLL_RECAL_BIT = 2;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_CAL_OK_BIT = 3;
	localparam int STAT_BAND_LO_BIT = 4;
	localparam int STAT_BAND_HI_BIT = 5;
	localparam int HALF_RATE_BIT = 5;
	localparam int RATE_DIV_LSB = 1;
	localparam int CDR_RST_BIT = 0;
	localparam int EQ_SEL_LSB = 6;
	// field encodings
	localparam logic [1:0] REF_MULT_X2 = 2'h1;
	localparam logic [1:0] REF_MULT_X1 = 2'h0;
	localparam logic [1:0] PD_DIV_1 = 2'h2;
	localparam logic [1:0] PD_DIV_2 = 2'h1;
	localparam logic [1:0] PD_DIV_4 = 2'h0;
	localparam logic [1:0] CDR_DIV_4 = 2'h2;
	localparam logic [1:0] CDR_DIV_2 = 2'h1;
	localparam logic [1:0] CDR_DIV_1 = 2'h0;
	localparam logic [1:0] EQ_LOW_POWER = 2'h1;
	localparam logic [1:0] EQ_NORMAL = 2'h0;
	// reset values and clock ratios
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] LANE_PD_RESET = 8'h00;
	localparam int REF_PER_LANE = 40;
	localparam int VCO_DIV = 2;
	localparam int BYTES_PER_PCLK = 4;
	localparam int CAL_CYCLES = 64;
	localparam int LOCK_CYCLES = 16;
	localparam int NUM_LANES = 8;
endpackage

/* spc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface spc_if;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd,
		input rdata);
endinterface
`default_nettype wire

/* spc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// orders come in over a plain register port; host registers:
// 0x0 cmd (write: bit0 start bring-up, bit1 recalibrate), 0x1 lane
// rate band (bits 1:0) and low-power equalizer (bit 2), 0x2 used-lane
// mask, 0x3 status (bit0 busy, bit1 locked, bit2 cal ok, bit3 band edge)
module spc_host (
	input wire logic clk, // 100 MHz
	input wire logic srst, // sync reset, high
	spc_if.host bus, // device register port
	input wire logic [3:0] cmd_addr, // host register address
	input wire logic [7:0] cmd_wdata, // host write data
	input wire logic cmd_wr, // write strobe
	input wire logic cmd_rd, // read strobe
	output logic [7:0] cmd_rdata // read data, cycle after strobe
);
	import spc_pkg::*;
	typedef enum logic [2:0] {
		SPC_IDLE = 3'b000,
		SPC_WRITE = 3'b001,
		SPC_POLL = 3'b010,
		SPC_WAIT = 3'b011,
		SPC_READ = 3'b100
	} spc_hst_t;
	localparam int NSTEP = 12;
	spc_hst_t st_ff;
	logic [3:0] step_ff;
	logic [1:0] band_ff;
	logic [7:0] used_ff;
	logic busy_ff, lock_ff, calok_ff, edge_ff, recal_only_ff;
	logic eq_low_ff;
	logic [11:0] addr_ff;
	logic [7:0] wdata_ff;
	logic wr_ff, rd_ff, poll_pend_ff;
	logic [7:0] cmd_rdata_ff;
	logic [11:0] s_addr;
	logic [7:0] s_data;
	assign bus.addr = addr_ff;
	assign bus.wdata = wdata_ff;
	assign bus.wr = wr_ff;
	assign bus.rd = rd_ff;
	assign cmd_rdata = cmd_rdata_ff;
	// bring-up script per lane-rate band
	always_comb
	begin
		logic [1:0] mult, pdiv, cdiv;
		logic half;
		mult = (band_ff == 2'd0) ? REF_MULT_X2 : REF_MULT_X1;
		pdiv = (band_ff <= 2'd1) ? PD_DIV_1 :
			(band_ff == 2'd2) ? PD_DIV_2 : PD_DIV_4;
		cdiv = (band_ff == 2'd0) ? CDR_DIV_4 :
			(band_ff == 2'd1) ? CDR_DIV_2 : CDR_DIV_1;
		half = (band_ff == 2'd3);
		s_addr = ADDR_REF_RATE;
		s_data = 8'h00;
		unique case (step_ff)
			4'd0: s_data = 8'(mult) << REF_MULT_LSB;
			4'd1: begin s_addr = ADDR_PLL_DIV; s_data = {6'h0, pdiv}; end
			4'd2: begin s_addr = ADDR_PLL_CTRL; s_data = 8'h01; end
			4'd3: begin s_addr = ADDR_PLL_CTRL; s_data = 8'h05; end
			4'd4: begin s_addr = ADDR_PLL_CTRL; s_data = 8'h01; end
			4'd5: begin
				s_addr = ADDR_CDR_MODE;
				s_data = (8'(half) << HALF_RATE_BIT) |
					(8'(cdiv) << RATE_DIV_LSB);
			end
			4'd6: begin s_addr = ADDR_CDR_RST; s_data = 8'h01; end
			4'd7: begin s_addr = ADDR_CDR_RST; s_data = 8'h00; end
			4'd8: begin s_addr = ADDR_LANE_PD; s_data = ~used_ff; end
			default:
			begin
				s_addr = ADDR_EQ_PWR;
				s_data = 8'(eq_low_ff ? EQ_LOW_POWER : EQ_NORMAL) << EQ_SEL_LSB;
			end
		endcase
	end
	always_ff @(posedge clk)
	begin
		wr_ff <= 1'b0;
		rd_ff <= 1'b0;
		if (srst)
		begin
			st_ff <= SPC_IDLE;
			step_ff <= 4'd0;
			addr_ff <= 12'h000;
			wdata_ff <= 8'h00;
			busy_ff <= 1'b0;
			lock_ff <= 1'b0;
			calok_ff <= 1'b0;
			edge_ff <= 1'b0;
			recal_only_ff <= 1'b0;
			poll_pend_ff <= 1'b0;
		end
		else
		begin
			unique case (st_ff)
				SPC_IDLE:
					if (cmd_wr && cmd_addr == 4'h0 && cmd_wdata[1:0] != 2'b00)
					begin
						recal_only_ff <= !cmd_wdata[0];
						step_ff <= cmd_wdata[0] ? 4'd0 : 4'd3;
						busy_ff <= 1'b1;
						st_ff <= SPC_WRITE;
					end
				SPC_WRITE:
				begin
					addr_ff <= s_addr;
					wdata_ff <= s_data;
					wr_ff <= 1'b1;
					if (step_ff == 4'd4 || step_ff == 4'(NSTEP - 3))
						st_ff <= SPC_POLL;
					else
						step_ff <= step_ff + 4'd1;
				end
				SPC_POLL:
				begin
					addr_ff <= ADDR_PLL_STAT;
					rd_ff <= 1'b1;
					st_ff <= SPC_READ;
				end
				// read data stand only in the cycle after the strobe
				SPC_READ: st_ff <= SPC_WAIT;
				SPC_WAIT:
				begin
					lock_ff <= bus.rdata[STAT_LOCK_BIT];
					calok_ff <= bus.rdata[STAT_CAL_OK_BIT];
					edge_ff <= bus.rdata[STAT_BAND_LO_BIT] |
						bus.rdata[STAT_BAND_HI_BIT];
					if (step_ff != 4'd4)
					begin
						busy_ff <= 1'b0;
						st_ff <= SPC_IDLE;
					end
					else if (bus.rdata[STAT_BAND_LO_BIT] |
						bus.rdata[STAT_BAND_HI_BIT])
					begin
						step_ff <= 4'd3; // band edge: recalibrate again
						st_ff <= SPC_WRITE;
					end
					else if (bus.rdata[STAT_CAL_OK_BIT])
					begin
						step_ff <= recal_only_ff ? 4'(NSTEP - 3) : 4'd5;
						st_ff <= SPC_WRITE;
					end
					else
						st_ff <= SPC_POLL;
				end
				default: st_ff <= SPC_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			band_ff <= 2'd0;
			eq_low_ff <= 1'b0;
			used_ff <= 8'h01;
		end
		else if (cmd_wr && !busy_ff)
		begin
			if (cmd_addr == 4'h1)
			begin
				band_ff <= cmd_wdata[1:0];
				eq_low_ff <= cmd_wdata[2];
			end
			if (cmd_addr == 4'h2)
				used_ff <= cmd_wdata;
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			cmd_rdata_ff <= 8'h00;
		else if (cmd_rd)
			unique case (cmd_addr)
				4'h1: cmd_rdata_ff <= {5'h00, eq_low_ff, band_ff};
				4'h2: cmd_rdata_ff <= used_ff;
				4'h3: cmd_rdata_ff <= {4'h0, edge_ff, calok_ff, lock_ff, busy_ff};
				default: cmd_rdata_ff <= 8'h00;
			endcase
		else
			cmd_rdata_ff <= 8'h00;
	end
endmodule
`default_nettype wire

/* spc_dev.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - frame to quad-byte clock ratio is 4/F
// - pll halves oscillator for quadrature clock
// - reference runs at lane rate over 40
// - divider keeps phase detector in window
// - ref multiplier double only lowest band
// - pll divider chosen by lane-rate band
// - program divider, then set enable bit
// - rising edge of bit 2 recalibrates
// - status bit 0 reports lock
// - status bit 3 marks calibration done
// - band-edge bits 4,5 demand recalibration
// - recovery clock comes from pll
// - half-rate recovery only above 6.25 Gbps
// - recovery rate divider set per band
// - each lane picks its phase independently
// - pulse recovery reset after configuring
// - power down every unused lane
// - equalizer field 01 low power, 00 normal
// - mask bit x powers down lane x
// - quad-byte clock is byte rate over 4
module spc_dev #(
	parameter int OCTETS_PER_FRAME = 1, // F
	parameter int CAL_LEN = 64 // calibration cycles
) (
	input wire logic clk, // 100 MHz
	input wire logic srst, // sync reset, high
	spc_if.dev bus, // register port
	input wire logic ref_tick, // reference clock tick, lane rate/40
	input wire logic band_edge_lo, // calibration hit lower end
	input wire logic band_edge_hi, // calibration hit upper end
	input wire logic lock_lost, // loop lost lock
	input wire logic [7:0] lane_phase_err, // per-lane early(1)/late(0)
	output logic [7:0] lane_power_down, // 1 = lane off
	output logic [7:0] lane_phase_step, // per-lane phase advance pulse
	output logic cdr_reset, // recovery reset
	output logic half_rate_select, // half-rate recovery
	output logic [1:0] recovery_rate_divider, // recovery divider
	output logic [1:0] phase_detector_divider, // ref divider code
	output logic [1:0] equalizer_power_select, // equalizer mode
	output logic low_power_eq, // low-power equalization active
	output logic quad_clk_en, // quadrature clock tick, vco/2
	output logic pclk_en, // quad-byte clock tick
	output logic frame_en // frame tick
);
	import spc_pkg::*;
	if (OCTETS_PER_FRAME != 1 && OCTETS_PER_FRAME != 2 &&
		OCTETS_PER_FRAME != 4)
		$error("octets per frame must be 1, 2 or 4");
	if (CAL_LEN < 1 || CAL_LEN > 255)
		$error("calibration length out of range");
	typedef enum logic [1:0] {
		SPC_OFF = 2'b00,
		SPC_CAL = 2'b01,
		SPC_LOCKING = 2'b10,
		SPC_LOCKED = 2'b11
	} spc_pll_t;
	spc_pll_t st_ff;
	logic [7:0] ref_rate_ff, pd_ff, cdr_rst_ff, cdr_mode_ff, eq_ff;
	logic [7:0] pll_ctrl_ff, pll_div_ff, rdata_ff, cnt_ff;
	logic recal_prev_ff, lock_ff, cal_ok_ff, lo_ff, hi_ff;
	logic quad_ff;
	logic [1:0] byte_cnt_ff;
	logic [7:0] phase_ff;
	logic [7:0] status;
	logic recal_rise;
	assign bus.rdata = rdata_ff;
	assign status = {2'b00, hi_ff, lo_ff, cal_ok_ff, 2'b00, lock_ff};
	assign recal_rise = pll_ctrl_ff[PLL_RECAL_BIT] & ~recal_prev_ff;
	// register writes; status has no write path
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ref_rate_ff <= REG_RESET;
			pd_ff <= LANE_PD_RESET;
			cdr_rst_ff <= REG_RESET;
			cdr_mode_ff <= REG_RESET;
			eq_ff <= REG_RESET;
			pll_ctrl_ff <= REG_RESET;
			pll_div_ff <= REG_RESET;
		end
		else if (bus.wr)
			unique case (bus.addr)
				ADDR_REF_RATE: ref_rate_ff <= bus.wdata;
				ADDR_LANE_PD: pd_ff <= bus.wdata;
				ADDR_CDR_RST: cdr_rst_ff <= bus.wdata;
				ADDR_CDR_MODE: cdr_mode_ff <= bus.wdata;
				ADDR_EQ_PWR: eq_ff <= bus.wdata;
				ADDR_PLL_CTRL: pll_ctrl_ff <= bus.wdata;
				ADDR_PLL_DIV: pll_div_ff <= bus.wdata;
				default: ;
			endcase
	end
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata_ff <= 8'h00;
		else if (bus.rd)
			unique case (bus.addr)
				ADDR_REF_RATE: rdata_ff <= ref_rate_ff;
				ADDR_LANE_PD: rdata_ff <= pd_ff;
				ADDR_CDR_RST: rdata_ff <= cdr_rst_ff;
				ADDR_CDR_MODE: rdata_ff <= cdr_mode_ff;
				ADDR_EQ_PWR: rdata_ff <= eq_ff;
				ADDR_PLL_CTRL: rdata_ff <= pll_ctrl_ff;
				ADDR_PLL_STAT: rdata_ff <= status;
				ADDR_PLL_DIV: rdata_ff <= pll_div_ff;
				default: rdata_ff <= 8'h00;
			endcase
		else
			rdata_ff <= 8'h00;
	end
	// pll model: calibrate, then lock
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_ff <= SPC_OFF;
			cnt_ff <= 8'h00;
			recal_prev_ff <= 1'b0;
			lock_ff <= 1'b0;
			cal_ok_ff <= 1'b0;
			lo_ff <= 1'b0;
			hi_ff <= 1'b0;
		end
		else
		begin
			recal_prev_ff <= pll_ctrl_ff[PLL_RECAL_BIT];
			if (!pll_ctrl_ff[PLL_EN_BIT])
			begin
				st_ff <= SPC_OFF;
				lock_ff <= 1'b0;
				cal_ok_ff <= 1'b0;
			end
			else if (st_ff == SPC_OFF || recal_rise)
			begin
				st_ff <= SPC_CAL;
				cnt_ff <= 8'(CAL_LEN);
				lock_ff <= 1'b0;
				cal_ok_ff <= 1'b0;
				lo_ff <= 1'b0;
				hi_ff <= 1'b0;
			end
			else
				unique case (st_ff)
					SPC_CAL:
						if (cnt_ff == 8'd1)
						begin
							lo_ff <= band_edge_lo;
							hi_ff <= band_edge_hi;
							cal_ok_ff <= !(band_edge_lo | band_edge_hi);
							st_ff <= (band_edge_lo | band_edge_hi) ?
								SPC_LOCKING : SPC_LOCKED;
							lock_ff <= !(band_edge_lo | band_edge_hi);
						end
						else
							cnt_ff <= cnt_ff - 8'd1;
					SPC_LOCKING: lock_ff <= 1'b0;
					SPC_LOCKED:
						if (lock_lost)
						begin
							lock_ff <= 1'b0;
							st_ff <= SPC_LOCKING;
						end
					default: st_ff <= SPC_OFF;
				endcase
		end
	end
	// clock ticks derived from the pll, not from lane transitions
	always_ff @(posedge clk)
	begin
		if (srst || !lock_ff)
		begin
			quad_ff <= 1'b0;
			byte_cnt_ff <= 2'd0;
			pclk_en <= 1'b0;
			frame_en <= 1'b0;
		end
		else
		begin
			quad_ff <= ~quad_ff;
			pclk_en <= 1'b0;
			frame_en <= 1'b0;
			if (ref_tick)
			begin
				byte_cnt_ff <= byte_cnt_ff + 2'd1;
				pclk_en <= (byte_cnt_ff == 2'(BYTES_PER_PCLK - 1));
				// frame every F bytes gives frame/pclk = 4/F
				if (OCTETS_PER_FRAME == 4)
					frame_en <= (byte_cnt_ff == 2'd3);
				else if (OCTETS_PER_FRAME == 2)
					frame_en <= byte_cnt_ff[0];
				else
					frame_en <= 1'b1;
			end
		end
	end
	// per-lane phase tracking
	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++)
		begin : g_lane
			always_ff @(posedge clk)
			begin
				if (srst || cdr_rst_ff[CDR_RST_BIT] || pd_ff[g])
					phase_ff[g] <= 1'b0;
				else
					phase_ff[g] <= lock_ff & lane_phase_err[g];
			end
		end
	endgenerate
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			lane_power_down <= 8'h00;
			lane_phase_step <= 8'h00;
			cdr_reset <= 1'b0;
			half_rate_select <= 1'b0;
			recovery_rate_divider <= CDR_DIV_1;
			phase_detector_divider <= PD_DIV_4;
			equalizer_power_select <= EQ_NORMAL;
			low_power_eq <= 1'b0;
			quad_clk_en <= 1'b0;
		end
		else
		begin
			lane_power_down <= pd_ff;
			lane_phase_step <= phase_ff;
			cdr_reset <= cdr_rst_ff[CDR_RST_BIT];
			half_rate_select <= cdr_mode_ff[HALF_RATE_BIT];
			recovery_rate_divider <= cdr_mode_ff[RATE_DIV_LSB +: 2];
			phase_detector_divider <= pll_div_ff[1:0];
			equalizer_power_select <= eq_ff[EQ_SEL_LSB +: 2];
			low_power_eq <= (eq_ff[EQ_SEL_LSB +: 2] == EQ_LOW_POWER);
			quad_clk_en <= quad_ff;
		end
	end
endmodule
`default_nettype wire

/* spc_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module spc_sva
	import spc_pkg::*;
#(
	parameter int CAL_LEN = 64 // calibration cycles
) (
	input wire logic clk, // clock
	input wire logic srst, // sync reset
	input wire logic [11:0] addr, // reg address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [7:0] rdata // read data
);
	logic div_seen_ff;
	logic recal_bit_ff;
	logic stat_rd_ff;
	logic [15:0] since_ff;
	logic ctrl_wr;
	assign ctrl_wr = wr && addr == ADDR_PLL_CTRL;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div_seen_ff <= 1'b0;
			stat_rd_ff <= 1'b0;
		end
		else
		begin
			div_seen_ff <= div_seen_ff || (wr && addr == ADDR_PLL_DIV);
			stat_rd_ff <= rd && addr == ADDR_PLL_STAT;
		end
	end
	// cycles since the last rising write of the recalibrate bit
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			recal_bit_ff <= 1'b0;
			since_ff <= 16'hffff;
		end
		else
		begin
			if (ctrl_wr)
				recal_bit_ff <= wdata[PLL_RECAL_BIT];
			if (ctrl_wr && wdata[PLL_RECAL_BIT] && !recal_bit_ff)
				since_ff <= 16'h0000;
			else if (since_ff != 16'hffff)
				since_ff <= since_ff + 16'h0001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_no_dual_strobe: assert property (!(wr && rd))
		else $error("read and write strobes together");
	a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside read cycle");
	a_div_before_en: assert property (
		ctrl_wr && wdata[PLL_EN_BIT] |-> div_seen_ff)
		else $error("pll enabled before divider written");
	a_recal_bit_release: assert property (
		ctrl_wr && wdata[PLL_RECAL_BIT]
		|-> ##[1:4] (ctrl_wr && !wdata[PLL_RECAL_BIT]))
		else $error("recalibrate bit not released");
	a_cdr_rst_pulse: assert property (
		wr && addr == ADDR_CDR_RST && wdata[CDR_RST_BIT]
		|-> ##[1:4] (wr && addr == ADDR_CDR_RST && !wdata[CDR_RST_BIT]))
		else $error("recovery reset not released");
	a_lock_implies_cal: assert property (
		stat_rd_ff && rdata[STAT_LOCK_BIT] |-> rdata[STAT_CAL_OK_BIT])
		else $error("lock without calibration done");
	a_lock_no_edge: assert property (
		stat_rd_ff && rdata[STAT_LOCK_BIT]
		|-> !rdata[STAT_BAND_LO_BIT] && !rdata[STAT_BAND_HI_BIT])
		else $error("lock reported at band edge");
	a_recal_drops_lock: assert property (
		stat_rd_ff && since_ff >= 16'd4 && since_ff < 16'(CAL_LEN)
		|-> !rdata[STAT_LOCK_BIT])
		else $error("lock reported during recalibration");
	a_eq_mode_legal: assert property (
		wr && addr == ADDR_EQ_PWR |-> wdata[7:6] == EQ_NORMAL
		|| wdata[7:6] == EQ_LOW_POWER)
		else $error("equalizer mode code reserved");
	a_ref_mult_legal: assert property (
		wr && addr == ADDR_REF_RATE |-> wdata[5:4] == REF_MULT_X2
		|| wdata[5:4] == REF_MULT_X1)
		else $error("bad reference multiplier");
	c_locked: cover property (stat_rd_ff && rdata[STAT_LOCK_BIT]);
	c_recal: cover property (ctrl_wr && wdata[PLL_RECAL_BIT]);
	c_edge: cover property (stat_rd_ff && (rdata[4] || rdata[5]));
endmodule
`default_nettype wire

/* spc_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module spc_tb;
	import spc_pkg::*;
	localparam int CAL = 16;
	localparam logic [1:0] PD_EXP [4] = '{PD_DIV_1, PD_DIV_1, PD_DIV_2, PD_DIV_4};
	localparam logic [1:0] CD_EXP [4] = '{CDR_DIV_4, CDR_DIV_2, CDR_DIV_1,
		CDR_DIV_1};
	localparam logic [7:0] USED [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] cmd_addr = 4'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_wr = 1'b0;
	logic cmd_rd = 1'b0;
	logic [7:0] cmd_rdata;
	logic ref_tick = 1'b0;
	logic edge_lo = 1'b0;
	logic edge_hi = 1'b0;
	logic lock_lost = 1'b0;
	logic [7:0] err_in = 8'h00;
	logic [7:0] lane_pd;
	logic [7:0] step;
	logic cdr_rst;
	logic half;
	logic [1:0] rrd;
	logic [1:0] pdd;
	logic [1:0] eqs;
	logic low_eq;
	logic quad;
	logic pclk_en;
	logic frame_en;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	spc_if bus ();
	spc_host i_spc_host (.clk(clk), .srst(srst), .bus(bus),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
	spc_dev #(.OCTETS_PER_FRAME(2), .CAL_LEN(CAL)) i_spc_dev (.clk(clk),
		.srst(srst), .bus(bus), .ref_tick(ref_tick), .band_edge_lo(edge_lo),
		.band_edge_hi(edge_hi), .lock_lost(lock_lost),
		.lane_phase_err(err_in), .lane_power_down(lane_pd),
		.lane_phase_step(step), .cdr_reset(cdr_rst),
		.half_rate_select(half), .recovery_rate_divider(rrd),
		.phase_detector_divider(pdd), .equalizer_power_select(eqs),
		.low_power_eq(low_eq), .quad_clk_en(quad), .pclk_en(pclk_en),
		.frame_en(frame_en));
	spc_sva #(.CAL_LEN(CAL)) i_spc_sva (.clk(clk), .srst(srst),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
		.rdata(bus.rdata));
	initial
	begin
		forever #5 clk = ~clk;
	end
	// one reference tick every other cycle
	always @(posedge clk)
		ref_tick <= ~ref_tick;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic hwr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
	endtask
	task automatic hrd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk);
		cmd_rd <= 1'b0;
		#1;
		d = cmd_rdata;
	endtask
	// bounded poll; a stuck busy shows as a mismatch, not a hang
	task automatic wait_idle();
		logic [7:0] s;
		int n;
		s = 8'h01;
		n = 0;
		while (s[0] !== 1'b0 && n < 300)
		begin
			hrd(4'h3, s);
			n++;
		end
		chk("idle", 8'h00, s & 8'h01);
	endtask
	task automatic t_reset();
		logic [7:0] s;
		hrd(4'h3, s);
		chk("host status", 8'h00, s);
		chk("pd div", {6'h0, PD_DIV_4}, {6'h0, pdd});
		chk("power down", 8'h00, lane_pd);
	endtask
	task automatic t_bringup(input int b);
		logic [7:0] s;
		logic [7:0] cfg;
		logic [1:0] eq_exp;
		// band 1 also runs the low-power equalizer
		cfg = 8'(b) | ((b == 1) ? 8'h04 : 8'h00);
		eq_exp = (b == 1) ? EQ_LOW_POWER : EQ_NORMAL;
		hwr(4'h1, cfg);
		hwr(4'h2, USED[b]);
		hwr(4'h0, 8'h01);
		wait_idle();
		hrd(4'h1, s);
		chk("band", cfg, s);
		hrd(4'h2, s);
		chk("used", USED[b], s);
		hrd(4'h3, s);
		chk("locked", 8'h06, s & 8'h06);
		chk("pd div", {6'h0, PD_EXP[b]}, {6'h0, pdd});
		chk("cdr div", {6'h0, CD_EXP[b]}, {6'h0, rrd});
		chk("half", {7'h0, b == 3}, {7'h0, half});
		chk("power down", ~USED[b], lane_pd);
		chk("eq", {6'h0, eq_exp}, {6'h0, eqs});
		chk("low eq", {7'h0, b == 1}, {7'h0, low_eq});
		chk("cdr rst", 8'h00, {7'h0, cdr_rst});
	endtask
	task automatic t_ratio();
		int np;
		int nf;
		int nq;
		np = 0;
		nf = 0;
		nq = 0;
		repeat (96)
		begin
			@(posedge clk);
			#1;
			np += int'(pclk_en);
			nf += int'(frame_en);
			nq += int'(quad);
		end
		chk("pclk", 8'd12, 8'(np));
		chk("frame", 8'd24, 8'(nf));
		chk("quad", 8'd48, 8'(nq));
	endtask
	// steps only on used lanes while locked, none after lock loss
	task automatic t_phase(input logic [7:0] used);
		logic [7:0] acc;
		logic [7:0] s;
		err_in <= 8'h5b;
		acc = 8'h00;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			acc |= step;
		end
		chk("phase step", 8'h5b & used, acc);
		lock_lost <= 1'b1;
		repeat (4) @(posedge clk);
		acc = 8'h00;
		repeat (8)
		begin
			@(posedge clk);
			#1;
			acc = acc | step | {7'h0, quad};
		end
		chk("lost lock", 8'h00, acc);
		lock_lost <= 1'b0;
		err_in <= 8'h00;
		hwr(4'h0, 8'h02);
		wait_idle();
		hrd(4'h3, s);
		chk("relocked", 8'h06, s & 8'h06);
	endtask
	task automatic t_band_edge();
		logic [7:0] s;
		for (int i = 1; i <= 2; i++)
		begin
			{edge_hi, edge_lo} <= 2'(i);
			hwr(4'h0, 8'h02);
			repeat (60) @(posedge clk);
			hrd(4'h3, s);
			chk("edge busy", 8'h01, s & 8'h01);
			{edge_hi, edge_lo} <= 2'b00;
			wait_idle();
			hrd(4'h3, s);
			chk("edge relock", 8'h06, s & 8'h06);
		end
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		for (int b = 3; b >= 0; b--)
			t_bringup(b);
		t_ratio();
		t_phase(USED[0]);
		t_band_edge();
		wrap_up();
	end
endmodule
`default_nettype wire
